// *** inc/rlc_defs.svh ***
// constants of the receive transport checksum checker
`ifndef RLC_DEFS_SVH
`define RLC_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define RLC_OFS_CTRL 4'h0
`define RLC_OFS_STAT 4'h4
`define RLC_OFS_VLAN 4'h8
`define RLC_CTRL_L4 0
`define RLC_CTRL_ICMP 1
`define RLC_CTRL_IGMP 2
`define RLC_STAT_ERR 0
`define RLC_STAT_CHK 1
`define RLC_STAT_FRAG 2
`define RLC_STAT_RAW 16
`define RLC_CTRL_RST 1'h0
`define RLC_VLAN_RST 16'h8100
// ----------------------------------------
// frame and protocol codes
// ----------------------------------------
`define RLC_ET_LEN_MAX 16'h0600
`define RLC_ET_IP4 16'h0800
`define RLC_ET_IP6 16'h86DD
`define RLC_PR_ICMP 8'h01
`define RLC_PR_IGMP 8'h02
`define RLC_PR_IPIP 8'h04
`define RLC_PR_TCP 8'h06
`define RLC_PR_UDP 8'h11
`define RLC_PR_IP6 8'h29
`define RLC_PR_HOP 8'h00
`define RLC_PR_ROUTE 8'h2B
`define RLC_PR_FRAG6 8'h2C
`define RLC_PR_ICMP6 8'h3A
`define RLC_PR_DEST 8'h3C
`define RLC_SUM_OK 16'hFFFF
// ----------------------------------------
// byte positions inside headers
// ----------------------------------------
`define RLC_MAC_LAST 16'h000D
`define RLC_VLAN_LAST 16'h0003
`define RLC_SNAP_LAST 16'h0007
`define RLC_IP4_VER 4'h4
`define RLC_IP6_VER 4'h6
`define RLC_IHL_MIN 4'h5
`define RLC_IP4_TLEN 16'h0003
`define RLC_IP4_SEEN 16'h0004
`define RLC_IP4_FRAG 16'h0007
`define RLC_IP4_MF 5
`define RLC_IP4_PROTO 16'h0009
`define RLC_IP4_SA 16'h000C
`define RLC_IP4_DA_END 16'h0013
`define RLC_IP6_PLEN 16'h0005
`define RLC_IP6_NH 16'h0006
`define RLC_IP6_SA 16'h0008
`define RLC_IP6_LAST 16'h0027
`define RLC_IP6_REST 16'h0022
`define RLC_UDP_LEN 16'h0005
`define RLC_UDP_CK 16'h0007
`endif

// *** inc/rlc_pkg.sv ***
// types of the receive transport checksum checker
package rlc_pkg;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rlc_beat_s;
    typedef struct packed {
        logic [15:0] raw_sum;
        logic frag;
        logic checked;
        logic err;
    } rlc_stat_s;
    typedef struct packed {
        logic l4_en;
        logic icmp_en;
        logic igmp_en;
        logic [15:0] vlan_type;
    } rlc_cfg_s;
    typedef struct packed {
        logic [15:0] cnt, seg, rem, lcnt, ulen, uck;
        logic [7:0] prev, hi, proto, lpad;
        logic [1:0] vl;
        logic odd, ip, v6, tun, frag, noc, trunc, l4s, lpend;
    } rlc_ctx_s;
    typedef enum {ST_IDLE, ST_MAC, ST_SNAP, ST_VLAN, ST_IP4, ST_IP6, ST_EXT, ST_L4, ST_DRAIN,
        ST_PAD, ST_PROTO, ST_LEN, ST_DONE} rlc_state_e;
endpackage : rlc_pkg

// *** rtl/rlc_csum_acc.sv ***
// ones-complement running sum
`timescale 1ns/1ps
`default_nettype none
module rlc_csum_acc #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic add,
    input wire logic [W-1:0] word,
    output logic [W-1:0] sum
);
    logic [W-1:0] sum_reg, sum_next;
    logic [W:0] t;
    always_comb begin
        t = {1'b0, sum_reg} + {1'b0, word};
        sum_next = sum_reg;
        if (clr) begin
            sum_next = '0;
        end else if (add) begin
            // end-around carry cannot overflow a second time
            sum_next = t[W-1:0] + {{(W-1){1'b0}}, t[W]};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_reg <= '0;
        end else begin
            sum_reg <= sum_next;
        end
    end
    assign sum = sum_reg;
endmodule : rlc_csum_acc
`default_nettype wire

// *** rtl/rlc_avs.sv ***
// avalon-mm register slave of the checksum checker
`timescale 1ns/1ps
`default_nettype none
`include "rlc_defs.svh"
module rlc_avs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output rlc_pkg::rlc_cfg_s cfg,
    input wire rlc_pkg::rlc_stat_s stat
);
    import rlc_pkg::*;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    rlc_cfg_s cfg_reg, cfg_next;
    always_comb begin
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        cfg_next = cfg_reg;
        // one wait state: data is ready when waitrequest drops
        if ((read || write) && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = 32'h0000_0000;
            if (read) begin
                unique case (address)
                    `RLC_OFS_CTRL: begin
                        rdata_next[`RLC_CTRL_L4] = cfg_reg.l4_en;
                        rdata_next[`RLC_CTRL_ICMP] = cfg_reg.icmp_en;
                        rdata_next[`RLC_CTRL_IGMP] = cfg_reg.igmp_en;
                    end
                    `RLC_OFS_STAT: begin
                        rdata_next[`RLC_STAT_ERR] = stat.err;
                        rdata_next[`RLC_STAT_CHK] = stat.checked;
                        rdata_next[`RLC_STAT_FRAG] = stat.frag;
                        rdata_next[`RLC_STAT_RAW+:16] = stat.raw_sum;
                    end
                    `RLC_OFS_VLAN: rdata_next[15:0] = cfg_reg.vlan_type;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
        // writes land on the edge that completes the transfer
        if (write && !wait_reg) begin
            if (address == `RLC_OFS_CTRL && byteenable[0]) begin
                cfg_next.l4_en = writedata[`RLC_CTRL_L4];
                cfg_next.icmp_en = writedata[`RLC_CTRL_ICMP];
                cfg_next.igmp_en = writedata[`RLC_CTRL_IGMP];
            end
            if (address == `RLC_OFS_VLAN && byteenable[0]) begin
                cfg_next.vlan_type[7:0] = writedata[7:0];
            end
            if (address == `RLC_OFS_VLAN && byteenable[1]) begin
                cfg_next.vlan_type[15:8] = writedata[15:8];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            cfg_reg <= '{`RLC_CTRL_RST, `RLC_CTRL_RST, `RLC_CTRL_RST, `RLC_VLAN_RST};
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
        end
    end
    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign cfg = cfg_reg;
endmodule : rlc_avs
`default_nettype wire

// *** rtl/rlc_checker.sv ***
// receive transport checksum checker: parser, sums, per-frame verdict
`timescale 1ns/1ps
`default_nettype none
`include "rlc_defs.svh"
module rlc_checker (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire rlc_pkg::rlc_beat_s RX_BEAT,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output var rlc_pkg::rlc_stat_s RX_STAT,
    output logic RX_STAT_VALID
);
    import rlc_pkg::*;
    rlc_cfg_s cfg;
    rlc_state_e st_reg, st_next;
    rlc_ctx_s ctx_reg, ctx_next;
    rlc_stat_s stat_reg, stat_next;
    logic svld_reg, svld_next;
    logic raw_clr, raw_add, l4_clr, l4_add;
    logic [15:0] raw_word, l4_word, raw_sum, l4_sum, etype;
    logic in_frame, in_l3, type_end, v6_end;
    logic is_tcp, is_udp, is_icmp, is_igmp, pseudo, uzero, chk;

    // ----------------------------------------
    // registers and sums
    // ----------------------------------------
    rlc_avs u_avs (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .address(AVS_ADDRESS),
        .read(AVS_READ),
        .write(AVS_WRITE),
        .writedata(AVS_WRITEDATA),
        .byteenable(AVS_BYTEENABLE),
        .readdata(AVS_READDATA),
        .waitrequest(AVS_WAITREQUEST),
        .cfg(cfg),
        .stat(stat_reg)
    );
    // raw sum pairs bytes low-first, as software expects
    rlc_csum_acc #(.W(16)) u_raw (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .clr(raw_clr),
        .add(raw_add),
        .word(raw_word),
        .sum(raw_sum)
    );
    rlc_csum_acc #(.W(16)) u_l4 (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .clr(l4_clr),
        .add(l4_add),
        .word(l4_word),
        .sum(l4_sum)
    );

    // ----------------------------------------
    // classification
    // ----------------------------------------
    assign in_frame = st_reg inside {ST_MAC, ST_SNAP, ST_VLAN, ST_IP4, ST_IP6, ST_EXT, ST_L4, ST_DRAIN};
    assign in_l3 = RX_BEAT.valid && (st_reg inside {ST_IP4, ST_IP6, ST_EXT, ST_L4, ST_DRAIN});
    assign etype = {ctx_reg.prev, RX_BEAT.data};
    assign type_end = (st_reg == ST_MAC && ctx_reg.cnt == `RLC_MAC_LAST)
        || (st_reg == ST_VLAN && ctx_reg.cnt == `RLC_VLAN_LAST)
        || (st_reg == ST_SNAP && ctx_reg.cnt == `RLC_SNAP_LAST);
    assign v6_end = (st_reg == ST_IP6 && ctx_reg.cnt == `RLC_IP6_LAST)
        || (st_reg == ST_EXT && ctx_reg.cnt > 16'h0001 && ctx_reg.cnt == ctx_reg.seg - 16'h0001);
    assign is_tcp = ctx_reg.proto == `RLC_PR_TCP;
    assign is_udp = ctx_reg.proto == `RLC_PR_UDP;
    assign is_icmp = ctx_reg.v6 ? ctx_reg.proto == `RLC_PR_ICMP6 : ctx_reg.proto == `RLC_PR_ICMP;
    // inner IPv6 never counts as IGMP
    assign is_igmp = !ctx_reg.v6 && ctx_reg.proto == `RLC_PR_IGMP;
    assign pseudo = ctx_reg.v6 || is_tcp || is_udp;
    assign uzero = is_udp && ctx_reg.uck == 16'h0000;
    assign chk = ctx_reg.ip && !ctx_reg.noc && !ctx_reg.frag && ctx_reg.l4s
        && (((is_tcp || is_udp) && cfg.l4_en) || (is_icmp && cfg.icmp_en)
        || (is_igmp && cfg.igmp_en))
        && !(uzero && !ctx_reg.v6);

    // ----------------------------------------
    // frame walker
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        ctx_next = ctx_reg;
        stat_next = stat_reg;
        svld_next = 1'b0;
        raw_clr = 1'b0;
        raw_add = 1'b0;
        l4_clr = 1'b0;
        l4_add = 1'b0;
        raw_word = {RX_BEAT.data, ctx_reg.hi};
        l4_word = {ctx_reg.hi, RX_BEAT.data};
        if (RX_BEAT.valid && RX_BEAT.sof && (in_frame || st_reg == ST_IDLE)) begin
            st_next = ST_MAC;
            ctx_next = '0;
            ctx_next.cnt = 16'h0001;
            raw_clr = 1'b1;
        end else if (RX_BEAT.valid && in_frame) begin
            ctx_next.prev = RX_BEAT.data;
            ctx_next.cnt = ctx_reg.cnt + 16'h0001;
            if (in_l3) begin
                ctx_next.odd = !ctx_reg.odd;
                raw_add = ctx_reg.odd;
                if (!ctx_reg.odd) begin
                    ctx_next.hi = RX_BEAT.data;
                end
                if (ctx_reg.rem != 16'h0000) begin
                    ctx_next.rem = ctx_reg.rem - 16'h0001;
                end
            end
            unique case (st_reg)
                ST_MAC, ST_SNAP, ST_VLAN: ;
                ST_IP4: begin
                    if (ctx_reg.cnt == 16'h0000) begin
                        ctx_next.seg = {10'h000, RX_BEAT.data[3:0], 2'b00};
                        if (RX_BEAT.data[7:4] != `RLC_IP4_VER || RX_BEAT.data[3:0] < `RLC_IHL_MIN) begin
                            ctx_next.noc = 1'b1;
                            st_next = ST_DRAIN;
                        end
                    end
                    if (ctx_reg.cnt == `RLC_IP4_TLEN) begin
                        ctx_next.rem = etype - `RLC_IP4_SEEN;
                    end
                    if (ctx_reg.cnt == `RLC_IP4_FRAG) begin
                        ctx_next.frag = ctx_reg.prev[`RLC_IP4_MF] || (|ctx_reg.prev[4:0]) || (|RX_BEAT.data);
                    end
                    if (ctx_reg.cnt == `RLC_IP4_PROTO) begin
                        ctx_next.proto = RX_BEAT.data;
                    end
                    // addresses enter the pseudo-header only for TCP and UDP
                    l4_add = ctx_reg.odd && (is_tcp || is_udp) && ctx_reg.cnt >= `RLC_IP4_SA
                        && ctx_reg.cnt <= `RLC_IP4_DA_END;
                    if (ctx_reg.cnt != 16'h0000 && ctx_reg.cnt == ctx_reg.seg - 16'h0001) begin
                        ctx_next.cnt = 16'h0000;
                        if (ctx_reg.proto == `RLC_PR_IPIP) begin
                            ctx_next.noc = 1'b1;
                            st_next = ST_DRAIN;
                        end else if (ctx_reg.proto == `RLC_PR_IP6) begin
                            ctx_next.tun = 1'b1;
                            ctx_next.v6 = 1'b1;
                            l4_clr = 1'b1;
                            st_next = ST_IP6;
                        end else begin
                            ctx_next.l4s = 1'b1;
                            st_next = ST_L4;
                        end
                    end
                end
                ST_IP6: begin
                    if (ctx_reg.cnt == 16'h0000 && RX_BEAT.data[7:4] != `RLC_IP6_VER) begin
                        ctx_next.noc = 1'b1;
                        st_next = ST_DRAIN;
                    end
                    if (ctx_reg.cnt == `RLC_IP6_PLEN) begin
                        ctx_next.rem = etype + `RLC_IP6_REST;
                    end
                    if (ctx_reg.cnt == `RLC_IP6_NH) begin
                        ctx_next.proto = RX_BEAT.data;
                    end
                    l4_add = ctx_reg.odd && ctx_reg.cnt >= `RLC_IP6_SA;
                end
                ST_EXT: begin
                    if (ctx_reg.cnt == 16'h0000) begin
                        ctx_next.proto = RX_BEAT.data;
                    end
                    if (ctx_reg.cnt == 16'h0001) begin
                        ctx_next.seg = {5'h00, RX_BEAT.data, 3'b000} + 16'h0008;
                    end
                end
                ST_L4: begin
                    // ethernet pad beyond the IP length stays out of the l4 sum
                    if (ctx_reg.rem != 16'h0000) begin
                        ctx_next.lcnt = ctx_reg.lcnt + 16'h0001;
                        l4_add = ctx_reg.odd;
                        ctx_next.lpend = !ctx_reg.odd;
                        if (!ctx_reg.odd) begin
                            ctx_next.lpad = RX_BEAT.data;
                        end
                        if (ctx_reg.lcnt == `RLC_UDP_LEN) begin
                            ctx_next.ulen = etype;
                        end
                        if (ctx_reg.lcnt == `RLC_UDP_CK) begin
                            ctx_next.uck = etype;
                        end
                    end
                    if (ctx_reg.rem <= 16'h0001) begin
                        st_next = ST_DRAIN;
                    end
                end
                ST_DRAIN, ST_IDLE, ST_PAD, ST_PROTO, ST_LEN, ST_DONE: ;
            endcase
            if (type_end) begin
                ctx_next.cnt = 16'h0000;
                ctx_next.odd = 1'b0;
                if (etype == cfg.vlan_type && ctx_reg.vl != 2'b10) begin
                    ctx_next.vl = ctx_reg.vl + 2'b01;
                    st_next = ST_VLAN;
                end else if (etype < `RLC_ET_LEN_MAX && st_reg == ST_MAC) begin
                    st_next = ST_SNAP;
                end else if (etype == `RLC_ET_IP4) begin
                    ctx_next.ip = 1'b1;
                    l4_clr = 1'b1;
                    st_next = ST_IP4;
                end else if (etype == `RLC_ET_IP6) begin
                    ctx_next.ip = 1'b1;
                    ctx_next.v6 = 1'b1;
                    l4_clr = 1'b1;
                    st_next = ST_IP6;
                end else begin
                    st_next = ST_DRAIN;
                end
            end
            if (v6_end) begin
                ctx_next.cnt = 16'h0000;
                if (ctx_reg.proto inside {`RLC_PR_HOP, `RLC_PR_ROUTE, `RLC_PR_DEST}) begin
                    st_next = ST_EXT;
                end else if (ctx_reg.proto == `RLC_PR_FRAG6) begin
                    ctx_next.frag = 1'b1;
                    st_next = ST_DRAIN;
                end else begin
                    ctx_next.l4s = 1'b1;
                    st_next = ST_L4;
                end
            end
            if (RX_BEAT.eof) begin
                st_next = ST_PAD;
                if (st_reg inside {ST_IP4, ST_IP6, ST_EXT} || (st_reg == ST_L4 && ctx_reg.rem > 16'h0001)) begin
                    ctx_next.trunc = 1'b1;
                end
            end
        end else begin
            unique case (st_reg)
                ST_PAD: begin
                    raw_add = ctx_reg.odd;
                    raw_word = {8'h00, ctx_reg.hi};
                    l4_add = ctx_reg.lpend;
                    l4_word = {ctx_reg.lpad, 8'h00};
                    st_next = ST_PROTO;
                end
                ST_PROTO: begin
                    l4_add = pseudo;
                    l4_word = {8'h00, ctx_reg.proto};
                    st_next = ST_LEN;
                end
                ST_LEN: begin
                    l4_add = pseudo;
                    l4_word = is_udp ? ctx_reg.ulen : ctx_reg.lcnt;
                    st_next = ST_DONE;
                end
                ST_DONE: begin
                    stat_next.raw_sum = raw_sum;
                    stat_next.frag = ctx_reg.frag;
                    stat_next.checked = chk;
                    stat_next.err = chk && (ctx_reg.trunc || l4_sum != `RLC_SUM_OK
                        || (uzero && ctx_reg.v6));
                    svld_next = 1'b1;
                    st_next = ST_IDLE;
                end
                ST_IDLE, ST_MAC, ST_SNAP, ST_VLAN, ST_IP4, ST_IP6, ST_EXT, ST_L4, ST_DRAIN: ;
            endcase
        end
    end
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= ST_IDLE;
            ctx_reg <= '0;
            stat_reg <= '0;
            svld_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ctx_reg <= ctx_next;
            stat_reg <= stat_next;
            svld_reg <= svld_next;
        end
    end
    assign RX_STAT = stat_reg;
    assign RX_STAT_VALID = svld_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_frame_end;
        RX_BEAT.valid && RX_BEAT.eof && !RX_BEAT.sof && in_frame;
    endsequence
    sequence s_one_pulse;
        RX_STAT_VALID ##1 !RX_STAT_VALID;
    endsequence
    a_one_verdict: assert property (s_frame_end |-> ##5 s_one_pulse) else $error("verdict not once");
    a_udp4_zero: assert property (st_reg == ST_DONE && uzero && !ctx_reg.v6 |=> !RX_STAT.err)
        else $error("ipv4 zero udp flagged");
    a_udp6_zero: assert property (st_reg == ST_DONE && uzero && ctx_reg.v6 && chk |=> RX_STAT.err)
        else $error("ipv6 zero udp passed");
    a_frag_skip: assert property (st_reg == ST_DONE && ctx_reg.frag |=> !RX_STAT.checked)
        else $error("fragment checked");
    a_icmp_gate: assert property (st_reg == ST_DONE && is_icmp && !cfg.icmp_en |=> !RX_STAT.checked)
        else $error("icmp checked while off");
    a_igmp_gate: assert property (st_reg == ST_DONE && is_igmp && !cfg.igmp_en |=> !RX_STAT.checked)
        else $error("igmp checked while off");
    a_non_ip: assert property (st_reg == ST_DONE && !ctx_reg.ip |=> !RX_STAT.checked)
        else $error("non-ip checked");
    a_tunnel_skip: assert property (st_reg == ST_DONE && ctx_reg.noc |=> !RX_STAT.checked)
        else $error("ip in ip checked");
    a_sum_error: assert property (st_reg == ST_DONE && chk && l4_sum != `RLC_SUM_OK |=> RX_STAT.err)
        else $error("bad sum passed");
    a_frag_mark: assert property (st_reg == ST_IP4 && in_l3 && !RX_BEAT.sof && ctx_reg.cnt == `RLC_IP4_FRAG
        && ctx_reg.prev[`RLC_IP4_MF] |=> ctx_reg.frag) else $error("mf not seen");
endmodule : rlc_checker
`default_nettype wire

// *** bench/rlc_mac_model.sv ***
// partner model: receive mac side streaming at most one frame byte per cycle, none while stall is high
`timescale 1ns/1ps
`default_nettype none
module rlc_mac_model
    import rlc_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic stall,
    input wire logic [7:0] len,
    input wire logic [0:127][7:0] img,
    output var rlc_pkg::rlc_beat_s beat,
    output var logic busy
);
    int idx = 0;
    initial beat = '0;
    initial busy = 1'b0;
    always @(posedge clk) begin
        beat.sof <= 1'b0;
        beat.eof <= 1'b0;
        if (busy && !stall) begin
            beat.valid <= 1'b1;
            beat.data <= img[idx];
            beat.sof <= (idx == 0);
            beat.eof <= (idx == len - 1);
            busy <= (idx != len - 1);
            idx <= idx + 1;
        end else begin
            beat.valid <= 1'b0;
            // idle lines toggle so no stale byte can pass for data
            beat.data <= ~beat.data;
        end
        if (go) begin
            busy <= 1'b1;
            idx <= 0;
        end
    end
endmodule : rlc_mac_model
`default_nettype wire

// *** bench/rx_l4_checksum_checker_bench.sv ***
// self-checking bench of the receive transport checksum checker
`timescale 1ns/1ps
`default_nettype none
module rx_l4_checksum_checker_bench;
    import rlc_pkg::*;
    logic SYS_CLK = 0;
    logic RESET_N = 0;
    logic [3:0] adr = '0;
    logic rd = 0, wr = 0, go = 0, stall = 0, busy, wreq, sv;
    logic [31:0] wdat = '0, rdat, rdv;
    rlc_beat_s beat;
    rlc_stat_s st;
    logic [0:127][7:0] fb = '0;
    logic [7:0] flen = 8'h40;
    int miscompares = 0, checked = 0, cyc = 0, seed = 97, c_mode;
    logic v6 = 0;
    logic [31:0] last_stat = '0;
    always #4 SYS_CLK = ~SYS_CLK;
    rlc_mac_model mac (.clk(SYS_CLK), .go(go), .stall(stall), .len(flen), .img(fb), .beat(beat), .busy(busy));
    rlc_checker dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RX_BEAT(beat), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .RX_STAT(st), .RX_STAT_VALID(sv));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        // no cycle count assumed: the wait ends when waitrequest drops, or else at the bench timeout
        do @(posedge SYS_CLK); while (wreq !== 1'b0);
        rdv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge SYS_CLK);
    endtask : bus
    function automatic logic [15:0] fold(input logic [31:0] s);
        s = s[15:0] + s[31:16];
        return s[15:0] + 16'(s[16]);
    endfunction : fold
    // mode 0 good, 1 corrupted, 2 zero field; ex is {frag, checked, err}; pr ff means non-ip
    task automatic frame(input logic [7:0] pr, input logic [15:0] fr, input int mode, input logic [2:0] ex);
        int n, c, b, p, h, u;
        logic [31:0] s, r;
        n = 8 + ($random(seed) & 31);
        h = v6 ? 54 : 34;
        flen = 8'(h + n);
        for (int i = 0; i < 128; i++) fb[i] = 8'($random(seed));
        if (v6) begin
            {fb[12], fb[13], fb[14]} = 24'h86_DD60;
            {fb[18], fb[19], fb[20]} = {16'(n), pr};
        end else begin
            {fb[12], fb[13], fb[14]} = 24'h08_0045;
            {fb[16], fb[17]} = 16'(20 + n);
            {fb[20], fb[21]} = fr;
            fb[23] = pr;
        end
        // ipv6 always carries a pseudo-header, ipv4 only for udp here
        u = (pr == 8'h11);
        p = u || v6;
        c = h + (u ? 6 : 2);
        b = p ? (v6 ? 22 : 26) : h;
        {fb[c], fb[c + 1]} = 16'h0000;
        if (u) {fb[h + 4], fb[h + 5]} = 16'(n);
        s = p ? 32'(pr + n) : 32'h0;
        for (int i = b; i < flen; i += 2) s += {fb[i], (i + 1 < flen) ? fb[i + 1] : 8'h00};
        {fb[c], fb[c + 1]} = (mode == 2) ? 16'h0000 : ~fold(s) ^ ((mode == 1) ? 16'h0100 : 16'h0000);
        if (pr == 8'hFF) fb[12] = 8'h88;
        r = 0;
        for (int i = 14; i < flen; i += 2) r += {(i + 1 < flen) ? fb[i + 1] : 8'h00, fb[i]};
        go <= 1'b1;
        @(posedge SYS_CLK);
        go <= 1'b0;
        n = 0;
        do @(posedge SYS_CLK); while (sv !== 1'b1 && ++n < 400);
        chk(sv, 1);
        chk({13'h0, st}, {13'h0, fold(r), ex});
        last_stat = {fold(r), 13'h0, ex};
        @(posedge SYS_CLK);
    endtask : frame
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge SYS_CLK) begin
        stall <= ($random(seed) & 3) == 0;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        bus(0, 4'h0, 0); chk(rdv, 32'h0000_0000);
        bus(0, 4'h8, 0); chk(rdv, 32'h0000_8100);
        bus(0, 4'hC, 0); chk(rdv, 32'h0000_0000);
        bus(1, 4'h0, 32'h0000_0007);
        bus(0, 4'h0, 0); chk(rdv, 32'h0000_0007);
        frame(8'h11, 16'h0000, 0, 3'b010);
        frame(8'h11, 16'h0000, 1, 3'b011);
        frame(8'h11, 16'h0000, 2, 3'b000);
        frame(8'h11, 16'h2000, 0, 3'b100);
        frame(8'h11, 16'h0005, 1, 3'b100);
        frame(8'h01, 16'h0000, 1, 3'b011);
        frame(8'h01, 16'h2000, 1, 3'b100);
        frame(8'h02, 16'h0000, 0, 3'b010);
        frame(8'h02, 16'h0010, 1, 3'b100);
        frame(8'h04, 16'h0000, 1, 3'b000);
        frame(8'h2F, 16'h0000, 1, 3'b000);
        frame(8'hFF, 16'h0000, 1, 3'b000);
        v6 = 1;
        frame(8'h11, 16'h0000, 0, 3'b010);
        frame(8'h11, 16'h0000, 2, 3'b011);
        frame(8'h3A, 16'h0000, 0, 3'b010);
        v6 = 0;
        repeat (6) begin
            c_mode = $random(seed) & 1;
            frame(8'h11, 16'h0000, c_mode, {2'b01, c_mode[0]});
        end
        bus(1, 4'h0, 32'h0000_0001);
        frame(8'h01, 16'h0000, 1, 3'b000);
        frame(8'h02, 16'h0000, 1, 3'b000);
        bus(0, 4'h4, 0); chk(rdv, last_stat);
        tally_and_finish;
    end
endmodule : rx_l4_checksum_checker_bench
`default_nettype wire
